// ===== ext_irq_pkg.sv
// Summary of operation
// - Edge field 00 turns fast detection off; the channel stays in standard mode.
// - Edge field 00 keeps the channel out of power-down entry and wake decisions.
// - Edge field 01 raises a request on each rising edge of the selected input.
// - Edge field 01 allows power-down only while input low; wakes when it rises.
// - Edge field 10 raises a request on each falling edge of the selected input.
// - Edge field 10 allows power-down only while input high; wakes when it falls.
// - Edge field 11 raises a request on both rising and falling edges.
// - Edge field 11 always allows power-down and wakes on any level change.
// - Source field 00 takes the channel input from its port 2 pin only.
// - Source field 01 takes the channel input from its alternate source only.
// - Source field 10 uses the OR of pin and alternate source.
// - Source field 11 uses the AND of pin and alternate source.
// - Channels 0-3 use pins 8-11 with CAN, RTC alternates; 4-7 use pins 12-15, alternate zero.
// - Extra source control register: request flag, enable, priority level, group level.
// - Priority level 4 bits, Fh highest; group level 2 bits, 3 highest.
// - Request flag reads 1 after its source requested; forwarded only when enabled.
package ext_irq_pkg;

  localparam int CHANNELS = 8;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_EXTRA_CTRL = 16'hf19e;
  localparam logic [15:0] IDX_EDGE_CFG = 16'hf1c0;
  localparam logic [15:0] IDX_SRC_SEL = 16'hf1da;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hf1e0;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hf1e1;
  localparam logic [15:0] IDX_PD_STATUS = 16'hf1e2;

  localparam logic [15:0] RST_EDGE_CFG = 16'h0000;
  localparam logic [15:0] RST_SRC_SEL = 16'h0000;
  localparam logic [7:0] RST_EXTRA_CTRL = 8'h00;
  localparam logic [9:0] RST_IRQ_STATUS = 10'h000;
  localparam logic [9:0] RST_IRQ_MASK = 10'h000;

  // Extra source control fields
  localparam int XC_REQ_BIT = 7;
  localparam int XC_EN_BIT = 6;
  localparam int XC_PRIO_LSB = 2;
  localparam int XC_PRIO_W = 4;
  localparam int XC_GROUP_LSB = 0;
  localparam int XC_GROUP_W = 2;

  // Interrupt status/mask layout
  localparam int ST_EXTRA_BIT = 8;
  localparam int ST_WAKE_BIT = 9;
  localparam int ST_W = 10;

  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_ALT = 2'h1;
  localparam logic [1:0] SRC_OR = 2'h2;
  localparam logic [1:0] SRC_AND = 2'h3;

  // Port 2 pin of channel 0; channels follow consecutively
  localparam int PIN_BASE = 8;
  localparam int ALT_CHANNELS = 4;

  typedef enum logic {PD_RUN, PD_DOWN} pd_state_type;

  function automatic logic select_source(input logic [1:0] sel, input logic pin,
                                         input logic alt);
    logic r;
    r = pin;
    case (sel)
      SRC_PIN: r = pin;
      SRC_ALT: r = alt;
      SRC_OR: r = pin | alt;
      SRC_AND: r = pin & alt;
      default: r = pin;
    endcase
    return r;
  endfunction : select_source

  function automatic logic [15:0] merge_lanes(input logic [15:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = wdata[7:0];
    if (strb[1]) r[15:8] = wdata[15:8];
    return r;
  endfunction : merge_lanes

endpackage : ext_irq_pkg

// ===== ext_irq_sync.sv
`timescale 1ns/1ns
module ext_irq_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] mid_q;
  logic [WIDTH-1:0] late_q;
  logic [WIDTH-1:0] agree;

  // First stage feeds only the second stage
  assign agree = ~(mid_q ^ late_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      mid_q <= '0;
      late_q <= '0;
      level_out <= '0;
    end else begin
      meta_q <= async_in;
      mid_q <= meta_q;
      late_q <= mid_q;
      // A change is accepted once two stages agree, filtering single-cycle glitches
      level_out <= (late_q & agree) | (level_out & ~agree);
    end
  end

endmodule : ext_irq_sync

// ===== ext_irq_channel.sv
`timescale 1ns/1ns
module ext_irq_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  input wire logic [1:0] ext_int_edge_field,
  output logic edge_hit,
  output logic pd_allow,
  output logic wake
);

  logic prev_q;
  logic rise;
  logic fall;

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  always_comb begin
    edge_hit = 1'b0;
    pd_allow = 1'b1;
    wake = 1'b0;
    case (ext_int_edge_field)
      ext_irq_pkg::EDGE_OFF: begin
        edge_hit = 1'b0;
        pd_allow = 1'b1;
        wake = 1'b0;
      end
      ext_irq_pkg::EDGE_RISE: begin
        edge_hit = rise;
        pd_allow = ~level;
        wake = level;
      end
      ext_irq_pkg::EDGE_FALL: begin
        edge_hit = fall;
        pd_allow = level;
        wake = ~level;
      end
      ext_irq_pkg::EDGE_ANY: begin
        edge_hit = rise | fall;
        pd_allow = 1'b1;
        wake = rise | fall;
      end
      default: begin
        edge_hit = 1'b0;
        pd_allow = 1'b1;
        wake = 1'b0;
      end
    endcase
  end

endmodule : ext_irq_channel

// ===== fast_external_interrupt_select.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module fast_external_interrupt_select #(
  parameter int ADDR_W = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port2_high_pins,
  input wire logic first_can_receive,
  input wire logic second_can_receive,
  input wire logic rtc_second_tick,
  input wire logic rtc_alarm_tick,
  input wire logic extra_source_event,
  input wire logic power_down_request,
  output logic [7:0] ext_int_request,
  output logic extra_source_request,
  output logic [3:0] priority_level,
  output logic [1:0] group_level,
  output logic powered_down,
  output logic wake_pulse,
  output logic irq
);

  localparam int N = ext_irq_pkg::CHANNELS;

  // Registers
  logic [15:0] edge_cfg_q;
  logic [15:0] src_sel_q;
  logic [7:0] extra_ctrl_q;
  logic [ext_irq_pkg::ST_W-1:0] irq_status_q;
  logic [ext_irq_pkg::ST_W-1:0] irq_mask_q;
  ext_irq_pkg::pd_state_type pd_state_q;
  ext_irq_pkg::pd_state_type pd_state_d;

  // APB decode
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic word_aligned;
  logic [15:0] word_idx;
  logic hit_extra;
  logic hit_edge;
  logic hit_src;
  logic hit_status;
  logic hit_mask;
  logic hit_pd;
  logic hit_any;
  logic [31:0] rd_word;
  logic wr_extra;
  logic wr_edge;
  logic wr_src;
  logic wr_status;
  logic wr_mask;
  logic [31:0] rd_extra;
  logic [31:0] rd_edge;
  logic [31:0] rd_src;
  logic [31:0] rd_status;
  logic [31:0] rd_mask;
  logic [31:0] rd_pd;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite & ~pslverr;
  assign word_aligned = (paddr[1:0] == 2'h0);
  assign word_idx = paddr[17:2];
  assign hit_extra = word_aligned & (word_idx == ext_irq_pkg::IDX_EXTRA_CTRL);
  assign hit_edge = word_aligned & (word_idx == ext_irq_pkg::IDX_EDGE_CFG);
  assign hit_src = word_aligned & (word_idx == ext_irq_pkg::IDX_SRC_SEL);
  assign hit_status = word_aligned & (word_idx == ext_irq_pkg::IDX_IRQ_STATUS);
  assign hit_mask = word_aligned & (word_idx == ext_irq_pkg::IDX_IRQ_MASK);
  assign hit_pd = word_aligned & (word_idx == ext_irq_pkg::IDX_PD_STATUS);
  assign hit_any = hit_extra | hit_edge | hit_src | hit_status | hit_mask | hit_pd;

  // Write strobes, one per writable register
  assign wr_extra = wr_en & hit_extra;
  assign wr_edge = wr_en & hit_edge;
  assign wr_src = wr_en & hit_src;
  assign wr_status = wr_en & hit_status;
  assign wr_mask = wr_en & hit_mask;

  // Reserved bits read as zero
  assign rd_extra = {24'h000000, extra_ctrl_q};
  assign rd_edge = {16'h0000, edge_cfg_q};
  assign rd_src = {16'h0000, src_sel_q};
  assign rd_status = {22'h000000, irq_status_q};
  assign rd_mask = {22'h000000, irq_mask_q};
  assign rd_pd = {31'h00000000, (pd_state_q == ext_irq_pkg::PD_DOWN)};
  assign rd_word = hit_extra ? rd_extra :
                   hit_edge ? rd_edge :
                   hit_src ? rd_src :
                   hit_status ? rd_status :
                   hit_mask ? rd_mask :
                   hit_pd ? rd_pd :
                   32'h00000000;

  // One wait-free access: data and ready are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase & ~hit_any;
    end
  end

  // Idle read data stays zero so a stale word is never seen outside an access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= (setup_phase & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  // Input synchronisation: pins and alternates separately, so the
  // combination below never sees an asynchronous glitch
  logic [7:0] pin_level;
  logic [3:0] alt_raw;
  logic [3:0] alt_level;

  assign alt_raw = {rtc_alarm_tick, rtc_second_tick, second_can_receive,
                    first_can_receive};

  ext_irq_sync #(
    .WIDTH(N)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(port2_high_pins),
    .level_out(pin_level)
  );

  ext_irq_sync #(
    .WIDTH(ext_irq_pkg::ALT_CHANNELS)
  ) u_alt_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(alt_raw),
    .level_out(alt_level)
  );

  // Per-channel source selection and edge detection
  logic [N-1:0] chan_level;
  logic [N-1:0] chan_hit;
  logic [N-1:0] chan_allow;
  logic [N-1:0] chan_wake;
  logic [N-1:0] alt_full;

  // Channels 4-7 have no alternate source
  assign alt_full = {4'h0, alt_level};

  for (genvar c = 0; c < N; c++) begin : g_chan
    assign chan_level[c] = ext_irq_pkg::select_source(src_sel_q[2*c +: 2],
                                                      pin_level[c], alt_full[c]);

    ext_irq_channel u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .level(chan_level[c]),
      .ext_int_edge_field(edge_cfg_q[2*c +: 2]),
      .edge_hit(chan_hit[c]),
      .pd_allow(chan_allow[c]),
      .wake(chan_wake[c])
    );
  end

  // Power-down entry and wake-up
  logic pd_enter_ok;
  logic any_wake;
  logic wake_event;

  assign pd_enter_ok = &chan_allow;
  assign any_wake = |chan_wake;
  assign wake_event = (pd_state_q == ext_irq_pkg::PD_DOWN) & any_wake;

  always_comb begin
    pd_state_d = pd_state_q;
    case (pd_state_q)
      ext_irq_pkg::PD_RUN: begin
        if (power_down_request && pd_enter_ok) begin
          pd_state_d = ext_irq_pkg::PD_DOWN;
        end
      end
      ext_irq_pkg::PD_DOWN: begin
        if (any_wake) begin
          pd_state_d = ext_irq_pkg::PD_RUN;
        end
      end
      default: pd_state_d = ext_irq_pkg::PD_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_state_q <= ext_irq_pkg::PD_RUN;
    end else begin
      pd_state_q <= pd_state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_down <= 1'b0;
    end else begin
      powered_down <= (pd_state_d == ext_irq_pkg::PD_DOWN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= wake_event;
    end
  end

  // Configuration registers
  logic [15:0] extra_merged;
  logic extra_req_d;

  assign extra_merged = ext_irq_pkg::merge_lanes({8'h00, extra_ctrl_q}, pwdata, pstrb);

  // New event wins over a software clear in the same cycle
  always_comb begin
    extra_req_d = extra_ctrl_q[ext_irq_pkg::XC_REQ_BIT];
    if (wr_extra && pstrb[0]) begin
      extra_req_d = pwdata[ext_irq_pkg::XC_REQ_BIT];
    end
    if (extra_source_event) begin
      extra_req_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cfg_q <= ext_irq_pkg::RST_EDGE_CFG;
    end else if (wr_edge) begin
      edge_cfg_q <= ext_irq_pkg::merge_lanes(edge_cfg_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sel_q <= ext_irq_pkg::RST_SRC_SEL;
    end else if (wr_src) begin
      src_sel_q <= ext_irq_pkg::merge_lanes(src_sel_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_ctrl_q <= ext_irq_pkg::RST_EXTRA_CTRL;
    end else begin
      if (wr_extra) begin
        extra_ctrl_q[6:0] <= extra_merged[6:0];
      end
      extra_ctrl_q[ext_irq_pkg::XC_REQ_BIT] <= extra_req_d;
    end
  end

  // Interrupt status, write one to clear; set wins over clear
  logic [ext_irq_pkg::ST_W-1:0] status_set;
  logic [ext_irq_pkg::ST_W-1:0] status_clr;
  logic [15:0] mask_merged;
  logic [15:0] clr_merged;

  assign status_set = {wake_event, extra_source_event, chan_hit};
  assign clr_merged = ext_irq_pkg::merge_lanes(16'h0000, pwdata, pstrb);
  assign status_clr = wr_status ? clr_merged[ext_irq_pkg::ST_W-1:0] :
                      {ext_irq_pkg::ST_W{1'b0}};
  assign mask_merged = ext_irq_pkg::merge_lanes({6'h00, irq_mask_q}, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= ext_irq_pkg::RST_IRQ_STATUS;
    end else begin
      irq_status_q <= (irq_status_q & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= ext_irq_pkg::RST_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_q <= mask_merged[ext_irq_pkg::ST_W-1:0];
    end
  end

  // Registered outputs
  logic [ext_irq_pkg::ST_W-1:0] status_next;

  assign status_next = (irq_status_q & ~status_clr) | status_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_int_request <= 8'h00;
    end else begin
      ext_int_request <= chan_hit;
    end
  end

  // Forwarded only while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extra_source_request <= 1'b0;
    end else begin
      extra_source_request <= extra_req_d &
                              extra_ctrl_q[ext_irq_pkg::XC_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_level <= 4'h0;
    end else begin
      priority_level <= extra_ctrl_q[ext_irq_pkg::XC_PRIO_LSB +:
                                     ext_irq_pkg::XC_PRIO_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_level <= 2'h0;
    end else begin
      group_level <= extra_ctrl_q[ext_irq_pkg::XC_GROUP_LSB +:
                                  ext_irq_pkg::XC_GROUP_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & irq_mask_q);
    end
  end

endmodule : fast_external_interrupt_select

// ===== fast_external_interrupt_select_asserts.sv
`timescale 1ns/1ns
module fast_external_interrupt_select_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic [7:0] port2_high_pins,
  input wire logic [7:0] ext_int_request,
  input wire logic power_down_request,
  input wire logic powered_down,
  input wire logic wake_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_read_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_wake_leaves_down: assert property (wake_pulse |-> !powered_down && $past(powered_down))
    else $error("wake without leaving power-down");
  a_down_needs_request: assert property ($rose(powered_down) |-> $past(power_down_request))
    else $error("power-down without request");
  a_wake_one_pulse: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  a_pin_edge_cause: assert property (ext_int_request[4] |->
    $past(port2_high_pins[4], 2) != $past(port2_high_pins[4], 8))
    else $error("request without pin change");
endmodule : fast_external_interrupt_select_asserts

bind fast_external_interrupt_select fast_external_interrupt_select_asserts asserts_i (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .port2_high_pins,
  .ext_int_request, .power_down_request, .powered_down, .wake_pulse);

// ===== ext_irq_lines.sv
`timescale 1ns/1ns
module ext_irq_lines (
  input wire logic pclk,
  output logic [7:0] pins,
  output logic [3:0] alts
);
  initial begin
    pins = 8'h00;
    alts = 4'h0;
  end
  // Lines move just after an edge, never in step with sampling
  task automatic set(input logic [7:0] p, input logic [3:0] a);
    @(posedge pclk);
    pins <= p;
    alts <= a;
  endtask : set
endmodule : ext_irq_lines

// ===== tb_fast_external_interrupt_select.sv
`timescale 1ns/1ns
module tb_fast_external_interrupt_select;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, priority_level, alts;
  logic [7:0] pins, ext_int_request;
  logic extra_source_event, power_down_request, extra_source_request;
  logic powered_down, wake_pulse;
  logic [1:0] group_level;
  int mismatches, total_checks, cycles;
  int cnt [8];

  ext_irq_lines ext_irq_lines_i (.pclk, .pins, .alts);
  fast_external_interrupt_select fast_external_interrupt_select_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .port2_high_pins(pins), .first_can_receive(alts[0]),
    .second_can_receive(alts[1]), .rtc_second_tick(alts[2]),
    .rtc_alarm_tick(alts[3]), .extra_source_event, .power_down_request,
    .ext_int_request, .extra_source_request, .priority_level, .group_level,
    .powered_down, .wake_pulse, .irq);

  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    for (int c = 0; c < 8; c++) if (ext_int_request[c] === 1'b1) cnt[c]++;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask : wr

  task automatic rdchk(input logic [15:0] i, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, i, 32'h0, r, e);
    chk(nm, r, x);
  endtask : rdchk

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rdchk(ext_irq_pkg::IDX_EXTRA_CTRL, 32'h0, "xctrl_rst");
    rdchk(ext_irq_pkg::IDX_EDGE_CFG, 32'h0, "edge_rst");
    rdchk(ext_irq_pkg::IDX_SRC_SEL, 32'h0, "src_rst");
    apb(1'b0, 16'h0001, 32'h0, r, e);
    chk("unmapped_err", e, 1'b1);
  endtask : t_regs

  task automatic t_edges();
    int b;
    for (int m = 0; m < 4; m++) begin
      wr(ext_irq_pkg::IDX_EDGE_CFG, 32'(m) << 8);
      b = cnt[4];
      ext_irq_lines_i.set(8'h10, 4'h0);
      cyc(10);
      chk("rise", cnt[4] - b, m % 2);
      b = cnt[4];
      ext_irq_lines_i.set(8'h00, 4'h0);
      cyc(10);
      chk("fall", cnt[4] - b, m / 2);
    end
  endtask : t_edges

  task automatic t_alts();
    int b [8];
    wr(ext_irq_pkg::IDX_EDGE_CFG, 32'h5555);
    wr(ext_irq_pkg::IDX_SRC_SEL, 32'h5555);
    b = cnt;
    // Pins high too: a design reading pins would fire channels 4 to 7
    ext_irq_lines_i.set(8'hff, 4'hf);
    cyc(10);
    ext_irq_lines_i.set(8'h00, 4'h0);
    cyc(10);
    for (int c = 0; c < 8; c++) chk("alt", cnt[c] - b[c], c < 4);
  endtask : t_alts

  task automatic t_select();
    int b;
    logic p, a;
    wr(ext_irq_pkg::IDX_EDGE_CFG, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(ext_irq_pkg::IDX_SRC_SEL, 32'(s));
      for (int k = 1; k < 4; k++) begin
        p = k[1];
        a = k[0];
        b = cnt[0];
        ext_irq_lines_i.set({7'h0, p}, {3'h0, a});
        cyc(10);
        ext_irq_lines_i.set(8'h00, 4'h0);
        cyc(10);
        chk("sel", cnt[0] - b, s == 0 ? p : s == 1 ? a : s == 2 ? p | a : p & a);
      end
    end
  endtask : t_select

  task automatic t_irq();
    wr(ext_irq_pkg::IDX_SRC_SEL, 32'h0);
    wr(ext_irq_pkg::IDX_IRQ_STATUS, 32'h3ff);
    ext_irq_lines_i.set(8'h01, 4'h0);
    cyc(10);
    ext_irq_lines_i.set(8'h00, 4'h0);
    cyc(10);
    rdchk(ext_irq_pkg::IDX_IRQ_STATUS, 32'h1, "status");
    chk("irq_masked", irq, 1'b0);
    wr(ext_irq_pkg::IDX_IRQ_MASK, 32'h1);
    cyc(2);
    chk("irq_on", irq, 1'b1);
    wr(ext_irq_pkg::IDX_IRQ_STATUS, 32'h1);
    cyc(2);
    chk("irq_off", irq, 1'b0);
    rdchk(ext_irq_pkg::IDX_IRQ_STATUS, 32'h0, "status_clr");
  endtask : t_irq

  task automatic t_extra();
    wr(ext_irq_pkg::IDX_EXTRA_CTRL, 32'h7f);
    extra_source_event <= 1'b1;
    @(posedge pclk);
    extra_source_event <= 1'b0;
    cyc(3);
    chk("xreq", extra_source_request, 1'b1);
    chk("prio", priority_level, 4'hf);
    chk("group", group_level, 2'h3);
    rdchk(ext_irq_pkg::IDX_EXTRA_CTRL, 32'hff, "xctrl");
    rdchk(ext_irq_pkg::IDX_IRQ_STATUS, 32'h100, "xstatus");
    // Flag kept set, enable dropped: forwarding must stop
    wr(ext_irq_pkg::IDX_EXTRA_CTRL, 32'hbf);
    cyc(3);
    chk("xreq_off", extra_source_request, 1'b0);
  endtask : t_extra

  task automatic pd_try(input logic [31:0] cfg);
    wr(ext_irq_pkg::IDX_EDGE_CFG, cfg);
    power_down_request <= 1'b1;
    cyc(5);
    power_down_request <= 1'b0;
    cyc(2);
  endtask : pd_try

  task automatic t_pd();
    pd_try(32'h100);
    chk("pd_rise", powered_down, 1'b1);
    ext_irq_lines_i.set(8'h10, 4'h0);
    cyc(10);
    chk("wake_rise", powered_down, 1'b0);
    ext_irq_lines_i.set(8'h00, 4'h0);
    cyc(10);
    pd_try(32'h200);
    chk("pd_fall_low", powered_down, 1'b0);
    pd_try(32'h0);
    chk("pd_off", powered_down, 1'b1);
    rdchk(ext_irq_pkg::IDX_PD_STATUS, 32'h1, "pd_reg");
    ext_irq_lines_i.set(8'h10, 4'h0);
    cyc(10);
    chk("off_stays", powered_down, 1'b1);
    wr(ext_irq_pkg::IDX_EDGE_CFG, 32'h300);
    ext_irq_lines_i.set(8'h00, 4'h0);
    cyc(10);
    chk("wake_any", powered_down, 1'b0);
  endtask : t_pd

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    extra_source_event = 1'b0;
    power_down_request = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_edges();
    t_alts();
    t_select();
    t_irq();
    t_extra();
    t_pd();
    end_of_test();
  end
endmodule : tb_fast_external_interrupt_select
